/* File: design/pin_ctrl.sv */
/*
 * Wake qualification, interrupt pulse generation and power-sync sequencing.
 * Assumes all inputs synchronous to CLK, an external pull-up on both
 * open-drain pins and a host that clears status by writing ones.
 */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module pin_ctrl
	import pin_ctrl_pkg::*;
#(
	parameter int OFF_LONG_CYC = OFF_DLY_LONG_CYC,
	parameter int WAKE_CYC = WAKE_FILT_CYC,
	parameter int PULSE_CYC = IRQ_PULSE_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire wake_cmp_t WAKE_INPUT_A,
	input wire wake_cmp_t WAKE_INPUT_B,
	input wire logic [MAIN_SRC_N-4:0] MAIN_EVENTS,
	input wire logic COMM_ERROR_IRQ,
	input wire logic [FS_SRC_N-1:0] FS_EVENTS,
	input wire logic POWER_REQ,
	input wire logic POWER_SYNC_LINE_I,
	output logic POWER_SYNC_LINE_O,
	output logic POWER_SYNC_LINE_OE,
	output logic IRQ_PULSE_OUT_N_O,
	output logic IRQ_PULSE_OUT_N_OE,
	output logic IRQ,
	output logic INTERNAL_BIAS_SUPPLY,
	output logic PRE_REGULATOR,
	output logic SEQ_DONE
);

	localparam int CW = 24;

	// All counters share one width, so every count must stay below its ceiling.
	if (WAKE_CYC < 1 || PULSE_CYC < 1 || OFF_LONG_CYC <= OFF_DLY_SHORT_CYC
		|| OFF_LONG_CYC >= 2 ** CW) begin
		$error("pin_ctrl: illegal timing parameters");
	end

	function automatic logic [CW-1:0] next_count(input logic hold, input logic [CW-1:0] c);
		next_count = hold ? ((c == '1) ? c : c + CW'(1)) : '0;
	endfunction

	// ==========================================================
	// Wake filtering
	logic [1:0] wake_q, wake_d;
	logic [CW-1:0] wcnt_a_q, wcnt_a_d, wcnt_b_q, wcnt_b_d;
	logic bias_q, bias_d;
	logic stby_q;
	logic [1:0] req_lvl, wake_edge;

	always_comb begin
		// Inputs in the hysteresis band hold the present level.
		req_lvl[0] = WAKE_INPUT_A.above_high ? 1'b1 : (WAKE_INPUT_A.below_low ? 1'b0 : wake_q[0]); // [RL4]
		req_lvl[1] = WAKE_INPUT_B.above_high ? 1'b1 : (WAKE_INPUT_B.below_low ? 1'b0 : wake_q[1]); // [RL4]
		// A bounce back to the old level restarts the count, so only a steady level is taken.
		wcnt_a_d = next_count(req_lvl[0] != wake_q[0], wcnt_a_q);
		wcnt_b_d = next_count(req_lvl[1] != wake_q[1], wcnt_b_q);
		wake_d = wake_q;
		if (wcnt_a_q >= CW'(WAKE_CYC - 1) && req_lvl[0] != wake_q[0])
			wake_d[0] = req_lvl[0]; // [RL1] [RL2] [RL5]
		if (wcnt_b_q >= CW'(WAKE_CYC - 1) && req_lvl[1] != wake_q[1])
			wake_d[1] = req_lvl[1]; // [RL1] [RL2] [RL5]
		wake_edge = wake_d ^ wake_q;
		bias_d = bias_q;
		if (WAKE_INPUT_A.above_high || WAKE_INPUT_B.above_high)
			bias_d = 1'b1; // [RL1]
		else if (stby_q && WAKE_INPUT_A.below_analog_low && WAKE_INPUT_B.below_analog_low)
			bias_d = 1'b0; // [RL3]
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wake_q <= 2'h0;
			wcnt_a_q <= '0;
			wcnt_b_q <= '0;
			bias_q <= 1'b0;
		end else if (CE) begin
			wake_q <= wake_d;
			wcnt_a_q <= wcnt_a_d;
			wcnt_b_q <= wcnt_b_d;
			bias_q <= bias_d;
		end
	end

	assign INTERNAL_BIAS_SUPPLY = bias_q;

	// ==========================================================
	// Interrupt status, mask and pulse
	logic [SRC_N-1:0] stat_q, stat_d, mask_q, mask_d, events, clr;
	logic [3:0] ctrl_q, ctrl_d;
	logic [CW-1:0] pcnt_q, pcnt_d;
	logic pulse_q, pulse_d, pend_q, pend_d;
	logic [31:0] rdata_q, rdata_d;
	bus_req_t req;
	seq_t seq_q, seq_d;

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign stby_q = ctrl_q[CTRL_STANDBY];

	always_comb begin
		// Status layout: main events, wake A and B transitions, comm error, then fail-safe sources.
		events = {FS_EVENTS, COMM_ERROR_IRQ, wake_edge, MAIN_EVENTS}; // [RL9] [RL10]
		clr = '0;
		mask_d = mask_q;
		ctrl_d = ctrl_q;
		if (req.wr) begin
			unique case (req.addr)
				REG_STAT_MAIN: clr[MAIN_SRC_N-1:0] = req.wdata[MAIN_SRC_N-1:0];
				REG_STAT_FS: clr[SRC_N-1:MAIN_SRC_N] = req.wdata[FS_SRC_N-1:0];
				REG_MASK_MAIN: mask_d[MAIN_SRC_N-1:0] = req.wdata[MAIN_SRC_N-1:0];
				REG_MASK_FS: mask_d[SRC_N-1:MAIN_SRC_N] = req.wdata[FS_SRC_N-1:0];
				REG_CTRL: ctrl_d = req.wdata[3:0];
				default: ;
			endcase
		end
		// A new event wins over a clear in the same cycle.
		stat_d = (stat_q & ~clr) | events;
		// Unmasked events that arrive during a pulse are kept pending.
		pend_d = pend_q | (|(events & ~mask_q)); // [RL6] [RL8]
		// A queued pulse starts one cycle after the last ends, so the host sees a fresh falling edge.
		pulse_d = pulse_q;
		pcnt_d = pcnt_q;
		if (pulse_q) begin
			pcnt_d = pcnt_q + CW'(1);
			if (pcnt_q == CW'(PULSE_CYC - 1))
				pulse_d = 1'b0; // [RL7]
		end else if (pend_q) begin
			pulse_d = 1'b1; // [RL6]
			pcnt_d = '0;
			pend_d = |(events & ~mask_q);
		end
		rdata_d = 32'h0000_0000;
		if (req.rd) begin
			unique case (req.addr)
				REG_STAT_MAIN: rdata_d = 32'(stat_q[MAIN_SRC_N-1:0]);
				REG_STAT_FS: rdata_d = 32'(stat_q[SRC_N-1:MAIN_SRC_N]);
				REG_MASK_MAIN: rdata_d = 32'(mask_q[MAIN_SRC_N-1:0]);
				REG_MASK_FS: rdata_d = 32'(mask_q[SRC_N-1:MAIN_SRC_N]);
				REG_CTRL: rdata_d = 32'(ctrl_q);
				REG_STATE: rdata_d = {24'h00_0000, bias_q, wake_q, seq_q, pulse_q, pend_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stat_q <= '0;
			mask_q <= SRC_N'(MASK_RESET);
			ctrl_q <= CTRL_RESET;
			pcnt_q <= '0;
			pulse_q <= 1'b0;
			pend_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (CE) begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			ctrl_q <= ctrl_d;
			pcnt_q <= pcnt_d;
			pulse_q <= pulse_d;
			pend_q <= pend_d;
			rdata_q <= rdata_d;
		end
	end

	assign RDATA = rdata_q;
	assign IRQ = |(stat_q & ~mask_q);
	assign IRQ_PULSE_OUT_N_O = 1'b0;
	assign IRQ_PULSE_OUT_N_OE = ~pulse_q; // [RL6]

	// ==========================================================
	// Power sequencing with sync line
	logic sync_q, sync_d, drive_q, drive_d;
	logic [CW-1:0] scnt_q, scnt_d, dcnt_q, dcnt_d;
	logic sync_en, partner_pmic, off_ext;

	always_comb begin
		sync_en = ctrl_q[CTRL_SYNC_EN];
		partner_pmic = ctrl_q[CTRL_PARTNER]; // [RL12]
		off_ext = ctrl_q[CTRL_OFF_EXT];
		scnt_d = next_count(POWER_SYNC_LINE_I != sync_q, scnt_q);
		sync_d = sync_q;
		if (POWER_SYNC_LINE_I != sync_q && scnt_q >= CW'(SYNC_FILT_CYC - 1))
			sync_d = POWER_SYNC_LINE_I; // [RL16]
		seq_d = seq_q;
		dcnt_d = '0;
		drive_d = 1'b0;
		unique case (seq_q)
			SEQ_OFF: if (POWER_REQ)
				seq_d = (sync_en && !partner_pmic) ? SEQ_SYNC_PRE : SEQ_PRE_ON; // [RL11]
			SEQ_SYNC_PRE: begin
				// Release our hold; the shared line rises once the twin also releases.
				if (!POWER_REQ)
					seq_d = SEQ_OFF;
				else if (sync_q)
					seq_d = SEQ_PRE_ON; // [RL13]
			end
			SEQ_PRE_ON: seq_d = (sync_en && partner_pmic) ? SEQ_SYNC_POST : SEQ_RUN; // [RL11]
			SEQ_SYNC_POST: begin
				if (!POWER_REQ)
					seq_d = SEQ_OFF_DLY;
				else if (sync_q)
					seq_d = SEQ_RUN; // [RL14]
			end
			SEQ_RUN: if (!POWER_REQ)
				seq_d = SEQ_OFF_DLY;
			// Only the long delay is a parameter, so a bench can shorten it without touching the default.
			SEQ_OFF_DLY: begin
				dcnt_d = dcnt_q + CW'(1);
				if (dcnt_q == CW'((off_ext ? OFF_LONG_CYC : OFF_DLY_SHORT_CYC) - 1))
					seq_d = SEQ_OFF; // [RL15]
			end
		endcase
		// Before power-up the line is held low so the partner waits on us.
		if (sync_en && (seq_q == SEQ_OFF || seq_q == SEQ_OFF_DLY) && seq_d != SEQ_SYNC_PRE)
			drive_d = 1'b1;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync_q <= 1'b0;
			scnt_q <= '0;
			dcnt_q <= '0;
			seq_q <= SEQ_OFF;
			drive_q <= 1'b0;
		end else if (CE) begin
			sync_q <= sync_d;
			scnt_q <= scnt_d;
			dcnt_q <= dcnt_d;
			seq_q <= seq_d;
			drive_q <= drive_d;
		end
	end

	assign POWER_SYNC_LINE_O = 1'b0; // [RL17]
	assign POWER_SYNC_LINE_OE = ~drive_q; // [RL17]
	assign PRE_REGULATOR = seq_q inside {SEQ_PRE_ON, SEQ_SYNC_POST, SEQ_RUN, SEQ_OFF_DLY};
	assign SEQ_DONE = seq_q == SEQ_RUN;

	// ==========================================================
	// Checks
	logic [CW-1:0] low_len;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			low_len <= '0;
		else if (CE)
			low_len <= pulse_q ? low_len + CW'(1) : '0;
	end

	pulse_len_a: assert property (@(posedge CLK) disable iff (RST) low_len <= CW'(PULSE_CYC)) // [RL7]
		else $error("interrupt pulse too long");
	pulse_start_a: assert property (@(posedge CLK) disable iff (RST)
		CE && !pulse_q && pend_q |=> pulse_q) // [RL6]
		else $error("pending interrupt gave no pulse");
	mask_block_a: assert property (@(posedge CLK) disable iff (RST)
		CE && !pend_q && !pulse_q && (events & ~mask_q) == '0 |=> !pend_q && !pulse_q) // [RL8]
		else $error("masked source raised a pulse");
	bias_on_a: assert property (@(posedge CLK) disable iff (RST)
		CE && WAKE_INPUT_A.above_high |=> bias_q) // [RL1]
		else $error("bias not started on wake");
	bias_off_a: assert property (@(posedge CLK) disable iff (RST)
		CE && stby_q && !WAKE_INPUT_A.above_high && !WAKE_INPUT_B.above_high
		&& WAKE_INPUT_A.below_analog_low && WAKE_INPUT_B.below_analog_low |=> !bias_q) // [RL3]
		else $error("bias not stopped in standby");
	wake_stable_a: assert property (@(posedge CLK) disable iff (RST)
		CE && $changed(wake_q[0]) |-> $past(wcnt_a_q) >= CW'(WAKE_CYC - 1)) // [RL5]
		else $error("wake accepted before filter time");
	sync_hold_a: assert property (@(posedge CLK) disable iff (RST)
		seq_q == SEQ_SYNC_POST && !sync_q && POWER_REQ && CE |=> seq_q == SEQ_SYNC_POST) // [RL14]
		else $error("sequence passed without power-good");
	twin_wait_a: assert property (@(posedge CLK) disable iff (RST)
		seq_q == SEQ_SYNC_PRE && !sync_q |=> !PRE_REGULATOR) // [RL13]
		else $error("pre-regulator started before twin ready");
	no_sync_a: assert property (@(posedge CLK) disable iff (RST)
		CE && !ctrl_q[CTRL_SYNC_EN] && seq_q == SEQ_OFF && POWER_REQ |=> seq_q == SEQ_PRE_ON) // [RL11]
		else $error("sequence waited with sync disabled");
	wake_b_filter_a: assert property (@(posedge CLK) disable iff (RST)
		CE && $changed(wake_q[1]) |-> $past(wcnt_b_q) >= CW'(WAKE_CYC - 1)) // [RL5]
		else $error("wake B accepted before filter time");
	bias_on_b_a: assert property (@(posedge CLK) disable iff (RST)
		CE && WAKE_INPUT_B.above_high |=> bias_q) // [RL1]
		else $error("bias not started on wake B");
	sync_filter_a: assert property (@(posedge CLK) disable iff (RST)
		CE && $changed(sync_q) |-> $past(scnt_q) >= CW'(SYNC_FILT_CYC - 1)) // [RL16]
		else $error("sync level accepted before filter time");
	off_delay_a: assert property (@(posedge CLK) disable iff (RST)
		CE && seq_q == SEQ_OFF_DLY && dcnt_q < CW'(OFF_DLY_SHORT_CYC - 1) |=> PRE_REGULATOR) // [RL15]
		else $error("pre-regulator dropped before off delay");
	sync_release_a: assert property (@(posedge CLK) disable iff (RST)
		CE && !ctrl_q[CTRL_SYNC_EN] |=> POWER_SYNC_LINE_OE) // [RL11]
		else $error("sync line driven while disabled");
	pend_keep_a: assert property (@(posedge CLK) disable iff (RST)
		CE && pulse_q && (events & ~mask_q) != '0 |=> pend_q) // [RL6]
		else $error("event during pulse was lost");
	stat_set_a: assert property (@(posedge CLK) disable iff (RST)
		CE && events[SRC_WAKE_A] |=> stat_q[SRC_WAKE_A]) // [RL9]
		else $error("wake transition not recorded");

endmodule

/* File: design/pin_ctrl_pkg.sv */
/*
 * Constants, types and timing figures for the wake, interrupt-pulse and
 * power-synchronisation pin logic.
 * Assumes a single 40 MHz clock domain; analog comparators outside this
 * block deliver the wake threshold results as synchronous digital levels.
 */
//
// Summary of operation
// RL1: Wake above high threshold: bias on, state 1.
// RL2: Wake below digital low threshold: state 0.
// RL3: Standby and both analog-low: bias off.
// RL4: Wake inputs judged as levels, not edges.
// RL5: Wake change accepted after stable filter time.
// RL6: Each interrupt event pulls output low once; events that arrive in one cycle or during one pulse share a single pulse.
// RL7: Interrupt pulse lasts nominally 100 microseconds.
// RL8: Masked sources produce no pulse.
// RL9: Main logic raises supply, wake, comm interrupts.
// RL10: Fail-safe logic raises monitor and watchdog interrupts.
// RL11: Sync waits only when enable bit set.
// RL12: Partner select: 0 twin, 1 external PMIC.
// RL13: Twin mode halts before pre-regulator until ready.
// RL14: PMIC mode halts after start until power-good.
// RL15: Pre-regulator off delay 250 us or 32 ms.
// RL16: Sync line feedback filtered about 10 us.
// RL17: Sync pin driven only low, open drain.
package pin_ctrl_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_KHZ = 40000;
	localparam int WAKE_FILT_US = 70;
	localparam int IRQ_PULSE_US = 100;
	localparam int SYNC_FILT_US = 10;
	localparam int OFF_DLY_SHORT_US = 250;
	localparam int OFF_DLY_LONG_MS = 32;
	localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_KHZ / 1000;
	localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * CLK_KHZ / 1000;
	localparam int SYNC_FILT_CYC = SYNC_FILT_US * CLK_KHZ / 1000;
	localparam int OFF_DLY_SHORT_CYC = OFF_DLY_SHORT_US * CLK_KHZ / 1000;
	localparam int OFF_DLY_LONG_CYC = OFF_DLY_LONG_MS * CLK_KHZ;

	// ==========================================================
	// Interrupt sources
	localparam int MAIN_SRC_N = 23;
	localparam int FS_SRC_N = 12;
	localparam int SRC_N = MAIN_SRC_N + FS_SRC_N;
	localparam int SRC_WAKE_A = 20;
	localparam int SRC_WAKE_B = 21;

	// ==========================================================
	// Register map
	localparam logic [3:0] REG_STAT_MAIN = 4'h0;
	localparam logic [3:0] REG_STAT_FS = 4'h1;
	localparam logic [3:0] REG_MASK_MAIN = 4'h2;
	localparam logic [3:0] REG_MASK_FS = 4'h3;
	localparam logic [3:0] REG_CTRL = 4'h4;
	localparam logic [3:0] REG_STATE = 4'h5;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam int CTRL_SYNC_EN = 0;
	localparam int CTRL_PARTNER = 1;
	localparam int CTRL_OFF_EXT = 2;
	localparam int CTRL_STANDBY = 3;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic above_high;
		logic below_low;
		logic below_analog_low;
	} wake_cmp_t;

	typedef enum logic [2:0] {
		SEQ_OFF = 3'b000,
		SEQ_SYNC_PRE = 3'b001,
		SEQ_PRE_ON = 3'b011,
		SEQ_SYNC_POST = 3'b010,
		SEQ_RUN = 3'b110,
		SEQ_OFF_DLY = 3'b100
	} seq_t;

endpackage

/* File: tb/pin_ctrl_tb.sv */
/*
 * Self-checking bench for the wake, interrupt-pulse and sync logic.
 * Assumes the short count parameters below and pull-ups on both pins.
 */
`timescale 1ns/10ps
module pin_ctrl_tb;
	import pin_ctrl_pkg::*;
	logic CLK, RST, CE, WR, RD, PREQ, HOLD, LINE, COMM, SO, SOE, IO, IOE, IRQ, BIAS, PRE, DONE;
	logic [3:0] ADDR;
	logic [31:0] WDATA, RDATA, st;
	logic [19:0] MEV;
	logic [11:0] FEV;
	wake_cmp_t WA, WB;
	wire irqn = IOE ? 1'b1 : IO;
	int failures = 0;
	int cmp_count = 0;

	// ==========================================================
	// Design and far party
	pin_ctrl #(.OFF_LONG_CYC(20000), .WAKE_CYC(8), .PULSE_CYC(16)) i_pin_ctrl (
		.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .WAKE_INPUT_A(WA), .WAKE_INPUT_B(WB), .MAIN_EVENTS(MEV),
		.COMM_ERROR_IRQ(COMM), .FS_EVENTS(FEV), .POWER_REQ(PREQ), .POWER_SYNC_LINE_I(LINE),
		.POWER_SYNC_LINE_O(SO), .POWER_SYNC_LINE_OE(SOE), .IRQ_PULSE_OUT_N_O(IO),
		.IRQ_PULSE_OUT_N_OE(IOE), .IRQ(IRQ), .INTERNAL_BIAS_SUPPLY(BIAS),
		.PRE_REGULATOR(PRE), .SEQ_DONE(DONE));
	sync_partner i_sync_partner (.hold(HOLD), .dev_oe(SOE), .dev_o(SO), .line(LINE));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		#1 st = RDATA;
	endtask
	task automatic clr();
		wr(REG_STAT_MAIN, 32'hFFFF_FFFF);
		wr(REG_STAT_FS, 32'hFFFF_FFFF);
	endtask
	task automatic ev(input logic [19:0] m, input logic [11:0] f, input logic c);
		@(posedge CLK);
		MEV <= m;
		FEV <= f;
		COMM <= c;
		@(posedge CLK);
		MEV <= 20'h0;
		FEV <= 12'h0;
		COMM <= 1'b0;
	endtask
	// Counts the low cycles of the next pulse; 0 when none starts within 40 cycles.
	task automatic pl(input int n);
		int i;
		int k;
		i = 0;
		k = 0;
		#1;
		while (irqn !== 1'b0 && i < 40) begin
			@(posedge CLK);
			#1 i++;
		end
		while (irqn === 1'b0 && k < 100) begin
			@(posedge CLK);
			#1 k++;
		end
		chk("pulse length", n, k);
	endtask
	task automatic wdone(input int lim);
		int i;
		i = 0;
		while (DONE !== 1'b1 && i < lim) begin
			@(posedge CLK);
			i++;
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		chk("sync oe", 1, SOE);
		wr(4'hF, 32'hFFFF_FFFF);
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0]);
			chk("reset read", 0, st);
		end
		wr(REG_MASK_MAIN, 32'h0000_0001);
		rd(REG_MASK_MAIN);
		chk("mask readback", 1, st);
		@(posedge CLK);
		CE <= 1'b0;
		wr(REG_MASK_FS, 32'h0000_0001);
		CE <= 1'b1;
		rd(REG_MASK_FS);
		chk("frozen write", 0, st);
		$display("register test done");
	endtask
	task automatic t_irq();
		ev(20'h2, 12'h0, 1'b0);
		pl(16);
		chk("irq level", 1, IRQ);
		rd(REG_STAT_MAIN);
		chk("status bit", 2, st & 32'h2);
		clr();
		chk("irq cleared", 0, IRQ);
		ev(20'h1, 12'h0, 1'b0);
		pl(0);
		chk("masked irq", 0, IRQ);
		clr();
		wr(REG_MASK_MAIN, 32'h0);
		ev(20'h0, 12'h1, 1'b0);
		pl(16);
		rd(REG_STAT_FS);
		chk("fs status", 1, st);
		ev(20'h0, 12'h0, 1'b1);
		pl(16);
		rd(REG_STAT_MAIN);
		chk("comm status", 32'h0040_0000, st);
		clr();
		// A second event inside a pulse must give exactly one more pulse.
		ev(20'h4, 12'h0, 1'b0);
		fork
			pl(16);
			begin
				wt(4);
				ev(20'h8, 12'h0, 1'b0);
			end
		join
		pl(16);
		pl(0);
		clr();
		$display("interrupt test done");
	endtask
	task automatic t_wake();
		@(posedge CLK);
		WA <= 3'h4;
		wt(4);
		WA <= 3'h3;
		pl(0);
		chk("bias on", 1, BIAS);
		@(posedge CLK);
		WA <= 3'h4;
		wt(1);
		rd(REG_STATE);
		chk("wake early", 0, st[6:5]);
		pl(16);
		rd(REG_STATE);
		chk("wake high", 1, |st[6:5]);
		rd(REG_STAT_MAIN);
		chk("wake status", 1, st[SRC_WAKE_A]);
		clr();
		WA <= 3'h3;
		pl(16);
		rd(REG_STATE);
		chk("wake low", 0, st[6:5]);
		chk("bias kept", 1, BIAS);
		clr();
		wr(REG_CTRL, 32'h8);
		wt(3);
		chk("bias off", 0, BIAS);
		wr(REG_CTRL, 32'h0);
		$display("wake test done");
	endtask
	task automatic t_seq(input logic [31:0] c, input int off);
		wr(REG_CTRL, c);
		HOLD <= 1'b1;
		// The line filter must settle on the low level before power is requested.
		wt(500);
		chk("sync drive", {30'h0, ~c[0], 1'b0}, {SOE, SO});
		PREQ <= 1'b1;
		wt(600);
		chk("pre wait", c[0] & ~c[1] ? 0 : 1, PRE);
		chk("done wait", c[0] ? 0 : 1, DONE);
		HOLD <= 1'b0;
		wdone(600);
		chk("sequence done", 3, {PRE, DONE});
		PREQ <= 1'b0;
		wt(off - 100);
		chk("pre held", 1, PRE);
		wt(200);
		chk("pre off", 0, PRE);
		$display("sequence test done");
	endtask

	// ==========================================================
	// Clock, reset, main sequence and watchdog
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	initial begin
		{RST, WR, RD, PREQ, HOLD, COMM} = 6'h20;
		CE = 1'b1;
		{ADDR, WDATA, MEV, FEV} = '0;
		WA = 3'h3;
		WB = 3'h3;
		wt(5);
		RST <= 1'b0;
		t_regs();
		t_irq();
		t_wake();
		t_seq(32'h1, 10000);
		t_seq(32'h7, 20000);
		t_seq(32'h0, 10000);
		give_verdict();
	end
	initial begin
		wt(60000);
		failures++;
		give_verdict();
	end
endmodule

/* File: tb/sync_partner.sv */
/*
 * Far party on the shared sync line: a twin device or an external
 * regulator whose power-good output is wired to the line.
 * Assumes a pull-up on the line; the bench decides when the party is ready.
 */
`timescale 1ns/10ps
module sync_partner (
	input wire logic hold,
	input wire logic dev_oe,
	input wire logic dev_o,
	output logic line
);
	// ==========================================================
	// Wired-AND line
	// While not ready the partner pulls low; once it and the device both release, the pull-up wins.
	assign line = (dev_oe | dev_o) & ~hold;
endmodule
